/* File: afe_regs_pkg.sv */
package afe_regs_pkg;

    // ------------------------------------------------------------
    // register indices (byte offsets on the local port)
    // ------------------------------------------------------------
    localparam logic [2:0] REGULATOR_CONTROL_OFS = 3'h0;
    localparam logic [2:0] AMP_SWITCH_CTRL_LOW_OFS = 3'h1;
    localparam logic [2:0] AMP_SWITCH_CTRL_HIGH_OFS = 3'h2;
    localparam logic [2:0] AMP_SUPPLY_SELECT_OFS = 3'h3;
    localparam logic [2:0] AMP_CONTROL_STATUS_OFS = 3'h4;
    localparam logic [2:0] AMP_OFFSET_TRIM_OFS = 3'h5;
    localparam logic [2:0] FEEDBACK_RES_CODE_LOW_OFS = 3'h6;
    localparam logic [2:0] FEEDBACK_RES_CODE_HIGH_OFS = 3'h7;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int LDO_REF_SWITCH_BIT = 7;
    localparam int NEG_INPUT_ROUTE_BIT = 4;
    localparam int AMP_ENABLE_BIT = 6;
    localparam int AMP_OUTPUT_STATE_BIT = 5;
    localparam int CALIB_MODE_BIT = 7;
    localparam int CALIB_REFERENCE_BIT = 6;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [5:0] OFFSET_TRIM_RESET = 6'h20;
    localparam logic [2:0] LDO_MODE_RESET = 3'h0;

    // ------------------------------------------------------------
    // decoded regulator modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LDO_HI_Z = 3'b000,
        LDO_BYPASS = 3'b001,
        LDO_ON_2V2 = 3'b010,
        LDO_ON_2V5 = 3'b011,
        LDO_ON_3V0 = 3'b100
    } ldo_state_type;

    // feedback resistance in kilohm
    localparam int FB_RES_BASE_KOHM = 1915;
    localparam int FB_RES_STEP_KOHM = 5;
    localparam int FB_RES_TOP_KOHM = 640;

endpackage : afe_regs_pkg

/* File: ldo_mode_decode.sv */
module ldo_mode_decode
    import afe_regs_pkg::*;
(
    input wire logic [2:0] ldo_mode_sel_in,
    output ldo_state_type ldo_state_out
);
    always_comb begin
        unique case (ldo_mode_sel_in[1:0])
            2'b00: ldo_state_out = LDO_HI_Z;
            2'b01: ldo_state_out = LDO_BYPASS;
            2'b10: ldo_state_out = ldo_mode_sel_in[2] ? LDO_ON_3V0
                                                      : LDO_ON_2V2;
            2'b11: ldo_state_out = ldo_mode_sel_in[2] ? LDO_ON_3V0
                                                      : LDO_ON_2V5;
        endcase
    end
endmodule : ldo_mode_decode

/* File: feedback_res_calc.sv */
module feedback_res_calc
    import afe_regs_pkg::*;
(
    input wire logic [7:0] feedback_code_low_in,
    input wire logic feedback_code_top_in,
    output logic [10:0] res_kohm_out
);
    logic [10:0] step_part;
    logic [10:0] top_part;
    always_comb begin
        step_part = 11'(feedback_code_low_in) * 11'(FB_RES_STEP_KOHM);
        top_part = feedback_code_top_in ? 11'(FB_RES_TOP_KOHM) : 11'h000;
        res_kohm_out = 11'(FB_RES_BASE_KOHM) - step_part - top_part;
    end
endmodule : feedback_res_calc

/* File: ldo_and_gas_afe_control_regs.sv */
// The placing of the registers and the strobed register port were decided locally.
module ldo_and_gas_afe_control_regs
    import afe_regs_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    output logic [7:0] rdata_out,
    input wire logic amp_comparator_in,
    output logic ldo_ref_switch_out,
    output logic [2:0] ldo_mode_sel_out,
    output ldo_state_type ldo_state_out,
    output logic [7:0] amp_switch_out,
    output logic amp_switch_8_out,
    output logic [1:0] amp_supply_sel_out,
    output logic amp_enable_out,
    output logic [1:0] amp_bandwidth_sel_out,
    output logic calib_mode_sel_out,
    output logic calib_reference_sel_out,
    output logic [5:0] offset_trim_code_out,
    output logic [7:0] feedback_code_low_out,
    output logic feedback_code_top_out,
    output logic [10:0] feedback_res_kohm_out
);

    // ------------------------------------------------------------
    // stored fields
    // ------------------------------------------------------------
    logic ldo_ref_switch;
    logic [2:0] ldo_mode_sel;
    logic [7:0] amp_switch_low;
    logic amp_switch_8;
    logic [1:0] amp_supply_sel;
    logic amp_enable;
    logic [1:0] amp_bandwidth_sel;
    logic calib_mode_sel;
    logic calib_reference_sel;
    logic [5:0] offset_trim_code;
    logic [7:0] feedback_code_low;
    logic feedback_code_top;
    logic comp_meta;
    logic comp_sync;
    logic amp_output_state;
    ldo_state_type next_ldo_state;
    logic [10:0] next_res_kohm;
    logic [7:0] next_rdata;

    function automatic logic wr(input logic [2:0] ofs);
        wr = write_in && (addr_in == ofs);
    endfunction : wr

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            ldo_ref_switch <= 1'b0;
            ldo_mode_sel <= LDO_MODE_RESET;
        end else if (wr(REGULATOR_CONTROL_OFS)) begin
            ldo_ref_switch <= wdata_in[LDO_REF_SWITCH_BIT];
            ldo_mode_sel <= wdata_in[2:0];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            amp_switch_low <= 8'h00;
            amp_switch_8 <= 1'b0;
            amp_supply_sel <= 2'h0;
        end else begin
            if (wr(AMP_SWITCH_CTRL_LOW_OFS)) begin
                amp_switch_low <= wdata_in;
            end
            if (wr(AMP_SWITCH_CTRL_HIGH_OFS)) begin
                amp_switch_8 <= wdata_in[0];
            end
            if (wr(AMP_SUPPLY_SELECT_OFS)) begin
                amp_supply_sel <= wdata_in[1:0];
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            amp_enable <= 1'b0;
            amp_bandwidth_sel <= 2'h0;
        end else if (wr(AMP_CONTROL_STATUS_OFS)) begin
            // the status bit is read only, so bit 5 of a write is dropped
            amp_enable <= wdata_in[AMP_ENABLE_BIT];
            amp_bandwidth_sel <= wdata_in[1:0];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            calib_mode_sel <= 1'b0;
            calib_reference_sel <= 1'b0;
            offset_trim_code <= OFFSET_TRIM_RESET;
        end else if (wr(AMP_OFFSET_TRIM_OFS)) begin
            calib_mode_sel <= wdata_in[CALIB_MODE_BIT];
            calib_reference_sel <= wdata_in[CALIB_REFERENCE_BIT];
            offset_trim_code <= wdata_in[5:0];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            feedback_code_low <= 8'h00;
            feedback_code_top <= 1'b0;
        end else begin
            if (wr(FEEDBACK_RES_CODE_LOW_OFS)) begin
                feedback_code_low <= wdata_in;
            end
            if (wr(FEEDBACK_RES_CODE_HIGH_OFS)) begin
                feedback_code_top <= wdata_in[0];
            end
        end
    end

    // ------------------------------------------------------------
    // amplifier comparator status
    // ------------------------------------------------------------
    // analog level, so two flops before anything looks at it
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
        end else begin
            comp_meta <= amp_comparator_in;
            comp_sync <= comp_meta;
        end
    end

    always_comb begin
        amp_output_state = calib_mode_sel & comp_sync;
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        unique case (addr_in)
            REGULATOR_CONTROL_OFS:
                next_rdata = {ldo_ref_switch, 4'h0, ldo_mode_sel};
            AMP_SWITCH_CTRL_LOW_OFS:
                next_rdata = amp_switch_low;
            AMP_SWITCH_CTRL_HIGH_OFS:
                next_rdata = {7'h00, amp_switch_8};
            AMP_SUPPLY_SELECT_OFS:
                next_rdata = {6'h00, amp_supply_sel};
            AMP_CONTROL_STATUS_OFS:
                next_rdata = {1'b0, amp_enable, amp_output_state,
                              3'h0, amp_bandwidth_sel};
            AMP_OFFSET_TRIM_OFS:
                next_rdata = {calib_mode_sel, calib_reference_sel,
                              offset_trim_code};
            FEEDBACK_RES_CODE_LOW_OFS:
                next_rdata = feedback_code_low;
            FEEDBACK_RES_CODE_HIGH_OFS:
                next_rdata = {7'h00, feedback_code_top};
        endcase
    end

    // data stands only in the cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= read_in ? next_rdata : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // analog control outputs
    // ------------------------------------------------------------
    ldo_mode_decode mode_decode (
        .ldo_mode_sel_in(ldo_mode_sel),
        .ldo_state_out(next_ldo_state)
    );

    feedback_res_calc res_calc (
        .feedback_code_low_in(feedback_code_low),
        .feedback_code_top_in(feedback_code_top),
        .res_kohm_out(next_res_kohm)
    );

    // outputs are flopped once more, so controls lag a write by one
    // further edge; keeps every output glitch free toward the analog
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            ldo_ref_switch_out <= 1'b0;
            ldo_mode_sel_out <= LDO_MODE_RESET;
            ldo_state_out <= LDO_HI_Z;
            amp_switch_out <= 8'h00;
            amp_switch_8_out <= 1'b0;
            amp_supply_sel_out <= 2'h0;
            amp_enable_out <= 1'b0;
            amp_bandwidth_sel_out <= 2'h0;
            calib_mode_sel_out <= 1'b0;
            calib_reference_sel_out <= 1'b0;
            offset_trim_code_out <= OFFSET_TRIM_RESET;
            feedback_code_low_out <= 8'h00;
            feedback_code_top_out <= 1'b0;
            feedback_res_kohm_out <= 11'(FB_RES_BASE_KOHM);
        end else begin
            ldo_ref_switch_out <= ldo_ref_switch;
            ldo_mode_sel_out <= ldo_mode_sel;
            ldo_state_out <= next_ldo_state;
            amp_switch_out <= amp_switch_low;
            amp_switch_8_out <= amp_switch_8;
            amp_supply_sel_out <= amp_supply_sel;
            amp_enable_out <= amp_enable;
            amp_bandwidth_sel_out <= amp_bandwidth_sel;
            calib_mode_sel_out <= calib_mode_sel;
            calib_reference_sel_out <= calib_reference_sel;
            offset_trim_code_out <= offset_trim_code;
            feedback_code_low_out <= feedback_code_low;
            feedback_code_top_out <= feedback_code_top;
            feedback_res_kohm_out <= next_res_kohm;
        end
    end

endmodule : ldo_and_gas_afe_control_regs

/* File: afe_regs_properties.sv */
module afe_regs_properties
    import afe_regs_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    input wire logic [7:0] rdata_out,
    input wire logic [2:0] ldo_mode_sel_out,
    input wire ldo_state_type ldo_state_out,
    input wire logic [7:0] amp_switch_out,
    input wire logic calib_mode_sel_out,
    input wire logic [5:0] offset_trim_code_out,
    input wire logic [7:0] feedback_code_low_out,
    input wire logic feedback_code_top_out,
    input wire logic [10:0] feedback_res_kohm_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    function automatic ldo_state_type state_of(input logic [2:0] m);
        return (m[1:0] == 2'b00) ? LDO_HI_Z : (m[1:0] == 2'b01) ? LDO_BYPASS :
            m[2] ? LDO_ON_3V0 : m[0] ? LDO_ON_2V5 : LDO_ON_2V2;
    endfunction : state_of

    ldo_map_a: assert property (ldo_state_out == state_of(ldo_mode_sel_out))
        else $error("regulator state does not match mode field");
    fb_res_a: assert property (feedback_res_kohm_out == 11'(1915
        - 5 * feedback_code_low_out - 640 * feedback_code_top_out))
        else $error("feedback resistance wrong");
    rd_idle_a: assert property (!$past(read_in) |-> rdata_out == 8'h00)
        else $error("read data outside its cycle");
    trim_wr_a: assert property (write_in && addr_in == 3'h5 |->
        ##2 offset_trim_code_out == $past(wdata_in[5:0], 2))
        else $error("trim write not applied");
    sw_wr_a: assert property (write_in && addr_in == 3'h1 |->
        ##2 amp_switch_out == $past(wdata_in, 2))
        else $error("switch write not applied");
    hi_unimpl_a: assert property (read_in && addr_in == 3'h2 |=>
        rdata_out[7:1] == 7'h00)
        else $error("unimplemented bits not zero");
    status_off_a: assert property (read_in && addr_in == 3'h4
        && !calib_mode_sel_out && !$past(write_in) |=> !rdata_out[5])
        else $error("status bit set outside calibration");
    post_reset_a: assert property (!$past(reset_n_in) |->
        offset_trim_code_out == 6'h20 && amp_switch_out == 8'h00)
        else $error("reset values wrong");

    cal_read_c: cover property (read_in && calib_mode_sel_out);
    status_hi_c: cover property (rdata_out[5]);
    top_code_c: cover property (feedback_code_top_out && &feedback_code_low_out);
endmodule : afe_regs_properties

bind ldo_and_gas_afe_control_regs afe_regs_properties afe_regs_properties_inst (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .write_in(write_in),
    .read_in(read_in),
    .rdata_out(rdata_out),
    .ldo_mode_sel_out(ldo_mode_sel_out),
    .ldo_state_out(ldo_state_out),
    .amp_switch_out(amp_switch_out),
    .calib_mode_sel_out(calib_mode_sel_out),
    .offset_trim_code_out(offset_trim_code_out),
    .feedback_code_low_out(feedback_code_low_out),
    .feedback_code_top_out(feedback_code_top_out),
    .feedback_res_kohm_out(feedback_res_kohm_out)
);

/* File: afe_analog_model.sv */
module afe_analog_model #(
    parameter logic [5:0] TRIP_CODE = 6'h25
) (
    input wire logic amp_enable_in,
    input wire logic [5:0] offset_trim_code_in,
    output logic amp_comparator_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // output trips once the trim passes the offset; a disabled amp sits low
    assign amp_comparator_out = (amp_enable_in === 1'b1)
        && (offset_trim_code_in >= TRIP_CODE);
endmodule : afe_analog_model

/* File: ldo_and_gas_afe_control_regs_tb.sv */
module ldo_and_gas_afe_control_regs_tb;
    import afe_regs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [5:0] TRIP = 6'h25;
    logic sys_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [2:0] addr_in = 3'h0;
    logic [7:0] wdata_in = 8'h00;
    logic write_in = 1'b0;
    logic read_in = 1'b0;
    logic amp_comparator_in;
    logic [7:0] rdata_out, amp_switch_out, feedback_code_low_out, d;
    logic ldo_ref_switch_out, amp_switch_8_out, amp_enable_out;
    logic calib_mode_sel_out, calib_reference_sel_out, feedback_code_top_out;
    logic [2:0] ldo_mode_sel_out, a;
    ldo_state_type ldo_state_out;
    logic [1:0] amp_supply_sel_out, amp_bandwidth_sel_out;
    logic [5:0] offset_trim_code_out, v1, v2;
    logic [10:0] feedback_res_kohm_out;
    logic [7:0] sh [8];
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    wire logic [48:0] outs = {ldo_ref_switch_out, ldo_mode_sel_out,
        ldo_state_out, amp_switch_out, amp_switch_8_out, amp_supply_sel_out,
        amp_enable_out, amp_bandwidth_sel_out, calib_mode_sel_out,
        calib_reference_sel_out, offset_trim_code_out, feedback_code_low_out,
        feedback_code_top_out, feedback_res_kohm_out};

    ldo_and_gas_afe_control_regs ldo_and_gas_afe_control_regs_inst (.*);
    afe_analog_model #(.TRIP_CODE(TRIP)) afe_analog_model_inst (
        .amp_enable_in(amp_enable_out),
        .offset_trim_code_in(offset_trim_code_out),
        .amp_comparator_out(amp_comparator_in)
    );

    initial begin
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    // cut a hang short well past the expected run length
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------
    function automatic logic [7:0] mask_of(input logic [2:0] ad);
        case (ad)
            3'h0: return 8'h87;
            3'h2, 3'h7: return 8'h01;
            3'h3: return 8'h03;
            3'h4: return 8'h43;
            default: return 8'hFF;
        endcase
    endfunction : mask_of
    function automatic logic [7:0] rd_exp(input logic [2:0] ad);
        logic st;
        st = sh[5][7] && sh[4][6] && (sh[5][5:0] >= TRIP);
        return (ad == 3'h4) ? ({2'b00, st, 5'h00} | sh[4]) : sh[ad];
    endfunction : rd_exp
    function automatic logic [48:0] out_exp();
        logic [2:0] m;
        logic [10:0] r;
        m = sh[0][2:0];
        r = 11'(1915 - 5 * sh[6] - 640 * sh[7][0]);
        return {sh[0][7], m, (m[1:0] == 2'b00) ? 3'b000 : (m[1:0] == 2'b01) ?
            3'b001 : m[2] ? 3'b100 : m, sh[1], sh[2][0], sh[3][1:0], sh[4][6],
            sh[4][1:0], sh[5], sh[6], sh[7][0], r};
    endfunction : out_exp

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask : check
    // leaves the strobe up so writes can follow back to back
    task automatic wr(input logic [2:0] ad, input logic [7:0] dt);
        write_in <= 1'b1;
        addr_in <= ad;
        wdata_in <= dt;
        @(posedge sys_clk_in);
        sh[ad] = dt & mask_of(ad);
    endtask : wr
    task automatic rd(input logic [2:0] ad);
        write_in <= 1'b0;
        read_in <= 1'b1;
        addr_in <= ad;
        @(posedge sys_clk_in);
        read_in <= 1'b0;
        @(posedge sys_clk_in);
        check("read data", 64'(rd_exp(ad)), 64'(rdata_out));
        check("controls", 64'(out_exp()), 64'(outs));
    endtask : rd
    task automatic cal_step(input logic [5:0] c);
        wr(3'h5, {2'b10, c});
        write_in <= 1'b0;
        repeat (6) @(posedge sys_clk_in);
        rd(3'h4);
    endtask : cal_step
    task automatic print_verdict();
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    initial begin
        int r;
        r = $urandom(32'hC878);
        foreach (sh[i]) sh[i] = 8'h00;
        sh[5] = 8'h20;
        repeat (3) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        @(posedge sys_clk_in);
        for (int i = 0; i < 8; i++) begin
            rd(3'(i));
        end
        for (int i = 0; i < 8; i++) begin
            wr(3'(i), (i == 5) ? 8'h7F : 8'hFF);
            rd(3'(i));
        end
        for (int i = 0; i < 8; i++) begin
            wr(3'h0, 8'(i));
            rd(3'h0);
        end
        for (int i = 0; i < 200; i++) begin
            a = 3'($urandom);
            d = 8'($urandom);
            d[7] = d[7] && (a != 3'h5);
            wr(a, d);
            rd(3'($urandom));
        end
        wr(3'h4, 8'h40);
        for (int c = 0; c < 64; c++) begin
            cal_step(6'(c));
            v1 = 6'(c);
            if (rdata_out[5] === 1'b1) break;
        end
        for (int c = 63; c >= 0; c--) begin
            cal_step(6'(c));
            v2 = 6'(c);
            if (rdata_out[5] === 1'b0) break;
        end
        check("trim search", 64'({v1, v2}), 64'({TRIP, TRIP - 6'h01}));
        wr(3'h5, {2'b10, 6'((7'(v1) + 7'(v2)) >> 1)});
        rd(3'h5);
        print_verdict();
    end
endmodule : ldo_and_gas_afe_control_regs_tb
